// file: verilog/rxpg_top.sv
// Receiver register paging: decodes accesses, steers paged offsets to port blocks.
// Assumes register blocks answer blk_rdata combinationally from blk_addr.
`timescale 1ns/1ps
module rxpg_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register access
   input wire logic acc_valid,
   input wire logic acc_write,
   input wire logic [rxpg_pkg::SRC_W-1:0] acc_src,
   input wire logic [7:0] acc_addr,
   input wire logic [7:0] acc_wdata,
   output logic acc_rvalid,
   output logic [7:0] acc_rdata,
   // Receiver port register blocks
   output logic [7:0] blk_addr,
   output logic [7:0] blk_wdata,
   output logic [3:0] blk_we,
   output logic [3:0] blk_re,
   input wire logic [7:0] blk_rdata [rxpg_pkg::NUM_PORTS]
);

   // ==========================================================
   // Page state bank
   rxpg_page_if pg ();

   rxpg_page_state u_state (
      .clk_sys(clk_sys),
      .rst(rst),
      .pg(pg)
   );

   // ==========================================================
   // Decode
   wire logic src_ok = acc_src < rxpg_pkg::SRC_W'(rxpg_pkg::NUM_SRC);
   wire logic take = acc_valid && src_ok;
   wire logic hit_sel = acc_addr == rxpg_pkg::SEL_OFFSET;
   wire logic hit_page = rxpg_pkg::is_paged(acc_addr);
   wire logic hit_sts = acc_addr == rxpg_pkg::STS1_OFFSET;
   wire logic from_link = rxpg_pkg::src_is_link(acc_src);
   wire logic [3:0] rd_onehot = 4'(1 << pg.rd_port);

   assign pg.src = acc_src;
   assign pg.sel_wr = take && acc_write && hit_sel;
   assign pg.sel_wdata = acc_wdata;

   wire logic [1:0] arrival_link_number =
      from_link ? rxpg_pkg::src_port(acc_src) : rxpg_pkg::LOCAL_ARRIVAL;
   wire logic [7:0] sel_rdata = {arrival_link_number, pg.rd_port, pg.we_mask};

   wire logic [3:0] next_blk_we = (take && acc_write && hit_page) ? pg.we_mask : 4'h0;
   wire logic [3:0] next_blk_re = (take && !acc_write && hit_page) ? rd_onehot : 4'h0;

   wire rxpg_pkg::rxpg_kind_e next_kind =
      hit_page ? rxpg_pkg::KIND_PAGE :
      hit_sel ? rxpg_pkg::KIND_SEL : rxpg_pkg::KIND_NONE;

   // ==========================================================
   // Stage one: strobes to blocks, read context
   logic s1_rd;
   logic s1_sts;
   logic [1:0] s1_port;
   logic [7:0] s1_sel_data;
   rxpg_pkg::rxpg_kind_e s1_kind;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         blk_addr <= 8'h00;
         blk_wdata <= 8'h00;
         blk_we <= 4'h0;
         blk_re <= 4'h0;
         s1_rd <= 1'b0;
         s1_sts <= 1'b0;
         s1_port <= 2'h0;
         s1_sel_data <= 8'h00;
         s1_kind <= rxpg_pkg::KIND_NONE;
      end
      else
      begin
         blk_addr <= acc_addr;
         blk_wdata <= acc_wdata;
         blk_we <= next_blk_we;
         blk_re <= next_blk_re;
         s1_rd <= take && !acc_write;
         s1_sts <= hit_sts;
         s1_port <= pg.rd_port;
         s1_sel_data <= sel_rdata;
         s1_kind <= next_kind;
      end
   end

   // ==========================================================
   // Stage two: read data return
   wire logic [7:0] page_raw = blk_rdata[s1_port];
   wire logic [7:0] page_rdata =
      s1_sts ? {s1_port, page_raw[rxpg_pkg::STS_PORT_LSB-1:0]} : page_raw;

   logic [7:0] next_rdata;
   always_comb
   begin
      unique case (s1_kind)
         rxpg_pkg::KIND_PAGE: next_rdata = page_rdata;
         rxpg_pkg::KIND_SEL: next_rdata = s1_sel_data;
         rxpg_pkg::KIND_NONE: next_rdata = rxpg_pkg::UNMAPPED_RDATA;
         default: next_rdata = rxpg_pkg::UNMAPPED_RDATA;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         acc_rvalid <= 1'b0;
         acc_rdata <= 8'h00;
      end
      else
      begin
         acc_rvalid <= s1_rd;
         acc_rdata <= s1_rd ? next_rdata : acc_rdata;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   paged_write_mask_a: assert property (
      (take && acc_write && hit_page) |=> (blk_we == $past(pg.we_mask)))
      else $error("paged write did not reach the enabled blocks");

   nonpaged_write_a: assert property (
      (take && acc_write && !hit_page) |=> (blk_we == 4'h0))
      else $error("write outside paged ranges reached a block");

   sel_not_paged_a: assert property (
      (take && hit_sel) |=> (blk_we == 4'h0 && blk_re == 4'h0))
      else $error("select register access was paged");

   read_block_a: assert property (
      (s1_rd && s1_kind == rxpg_pkg::KIND_PAGE && !s1_sts) |=>
         (acc_rvalid && acc_rdata == $past(blk_rdata[s1_port])))
      else $error("paged read returned the wrong block");

   read_strobe_a: assert property (
      (take && !acc_write && hit_page) |=> (blk_re == 4'(1 << $past(pg.rd_port))))
      else $error("read strobe not on the selected block");

   local_arrival_a: assert property (
      (take && !acc_write && hit_sel && !from_link) |-> ##2 (acc_rdata[7:6] == 2'h0))
      else $error("local read of arrival link number not zero");

   link_arrival_a: assert property (
      (take && !acc_write && hit_sel && from_link) |-> ##2
         (acc_rvalid &&
          acc_rdata[7:6] == 2'($past(acc_src, 2) - rxpg_pkg::SRC_W'(rxpg_pkg::NUM_LOCAL))))
      else $error("link read of arrival link number wrong");

   status_port_a: assert property (
      (take && !acc_write && hit_sts) |-> ##2 (acc_rdata[7:6] == $past(pg.rd_port, 2)))
      else $error("status port field does not show read port");

   read_timing_a: assert property (
      (take && !acc_write) |-> ##2 acc_rvalid)
      else $error("read answer not two cycles after request");

   no_stray_answer_a: assert property (
      !(take && !acc_write) |-> ##2 !acc_rvalid)
      else $error("read answer without a read request");

   sel_read_fields_a: assert property (
      (take && !acc_write && hit_sel) |-> ##2
         (acc_rdata[5:4] == $past(pg.rd_port, 2) && acc_rdata[3:0] == $past(pg.we_mask, 2)))
      else $error("select readback does not show this source's paging");

   unmapped_read_a: assert property (
      (take && !acc_write && !hit_page && !hit_sel) |-> ##2
         (acc_rvalid && acc_rdata == rxpg_pkg::UNMAPPED_RDATA))
      else $error("read outside mapped offsets not zero");

   page_addr_a: assert property (
      (take && hit_page) |=> (blk_addr == $past(acc_addr)))
      else $error("paged access not steered with its offset");

   page_wdata_a: assert property (
      (take && acc_write && hit_page) |=> (blk_wdata == $past(acc_wdata)))
      else $error("paged write data not passed to the blocks");

   read_no_write_a: assert property (
      (take && !acc_write) |=> (blk_we == 4'h0))
      else $error("read access raised a block write");

   write_no_read_a: assert property (
      (take && acc_write) |=> (blk_re == 4'h0))
      else $error("write access raised a block read strobe");

   refused_src_a: assert property (
      (acc_valid && acc_src >= rxpg_pkg::SRC_W'(rxpg_pkg::NUM_SRC)) |=>
         (blk_we == 4'h0 && blk_re == 4'h0))
      else $error("access from an unknown source reached the blocks");

   broadcast_c: cover property (take && acc_write && hit_page && pg.we_mask == 4'hF);
   link_sel_read_c: cover property (take && !acc_write && hit_sel && from_link);
   page_b_read_c: cover property (take && !acc_write && acc_addr == rxpg_pkg::PAGE_B_HI);
   status_read_c: cover property (take && !acc_write && hit_sts);
   sel_then_write_c: cover property ((take && acc_write && hit_sel) ##1
      (take && acc_write && hit_page));

endmodule : rxpg_top

// file: common/rxpg_pkg.sv
// Constants, types and helpers for the receiver register paging block.
// Assumes one register clock; access sources are numbered locals first, then link ports.
package rxpg_pkg;

   // ==========================================================
   // Sizes
   localparam int NUM_PORTS = 4;
   localparam int NUM_LOCAL = 2;
   localparam int NUM_SRC = NUM_LOCAL + NUM_PORTS;
   localparam int SRC_W = 3;

   // ==========================================================
   // Offsets
   localparam logic [7:0] SEL_OFFSET = 8'h4C;
   localparam logic [7:0] STS1_OFFSET = 8'h4D;
   localparam logic [7:0] PAGE_A_LO = 8'h4D;
   localparam logic [7:0] PAGE_A_HI = 8'h7F;
   localparam logic [7:0] PAGE_B_LO = 8'hD0;
   localparam logic [7:0] PAGE_B_HI = 8'hDF;

   // ==========================================================
   // Field positions
   localparam int ARRIVAL_LSB = 6;
   localparam int READ_LSB = 4;
   localparam int WE_LSB = 0;
   localparam int STS_PORT_LSB = 6;

   // ==========================================================
   // Reset and fixed values
   localparam logic [1:0] LOCAL_READ_RST = 2'h0;
   localparam logic [3:0] LOCAL_WE_RST = 4'h0;
   localparam logic [1:0] LOCAL_ARRIVAL = 2'h0;
   localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      KIND_NONE = 2'b00,
      KIND_SEL = 2'b01,
      KIND_PAGE = 2'b10
   } rxpg_kind_e;

   // ==========================================================
   // Helpers
   function automatic logic is_paged(input logic [7:0] addr);
      return (addr >= PAGE_A_LO && addr <= PAGE_A_HI) ||
             (addr >= PAGE_B_LO && addr <= PAGE_B_HI);
   endfunction : is_paged

   function automatic logic src_is_link(input logic [SRC_W-1:0] src);
      return src >= SRC_W'(NUM_LOCAL);
   endfunction : src_is_link

   function automatic logic [1:0] src_port(input logic [SRC_W-1:0] src);
      logic [SRC_W-1:0] d;
      d = src - SRC_W'(NUM_LOCAL);
      return d[1:0];
   endfunction : src_port

endpackage : rxpg_pkg

// file: common/rxpg_page_if.sv
// Carrier between the access decoder and the per-source page state bank.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface rxpg_page_if;
   logic [rxpg_pkg::SRC_W-1:0] src;
   logic sel_wr;
   logic [7:0] sel_wdata;
   logic [1:0] rd_port;
   logic [3:0] we_mask;

   modport ctrl (output src, output sel_wr, output sel_wdata, input rd_port, input we_mask);
   modport bank (input src, input sel_wr, input sel_wdata, output rd_port, output we_mask);
endinterface : rxpg_page_if

// file: verilog/rxpg_page_state.sv
// Per-source page selection bank: one read selector and write mask per source.
// Assumes src is in range whenever sel_wr is high.
`timescale 1ns/1ps
module rxpg_page_state (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Decoder side
   rxpg_page_if.bank pg
);

   localparam int NSRC = rxpg_pkg::NUM_SRC;

   logic [1:0] sel_rd [NSRC];
   logic [3:0] sel_we [NSRC];

   // ==========================================================
   // Reset values per source
   function automatic logic [1:0] rst_rd(input int s);
      if (s >= rxpg_pkg::NUM_LOCAL)
         return 2'(s - rxpg_pkg::NUM_LOCAL);
      return rxpg_pkg::LOCAL_READ_RST;
   endfunction : rst_rd

   function automatic logic [3:0] rst_we(input int s);
      if (s >= rxpg_pkg::NUM_LOCAL)
         return 4'(1 << (s - rxpg_pkg::NUM_LOCAL));
      return rxpg_pkg::LOCAL_WE_RST;
   endfunction : rst_we

   // ==========================================================
   // State per source
   for (genvar s = 0; s < NSRC; s++)
   begin : g_src
      wire logic hit = pg.sel_wr && (pg.src == rxpg_pkg::SRC_W'(s));
      always_ff @(posedge clk_sys)
      begin
         if (rst)
         begin
            sel_rd[s] <= rst_rd(s);
            sel_we[s] <= rst_we(s);
         end
         else if (hit)
         begin
            sel_rd[s] <= pg.sel_wdata[rxpg_pkg::READ_LSB +: 2];
            sel_we[s] <= pg.sel_wdata[rxpg_pkg::WE_LSB +: 4];
         end
      end
   end

   // ==========================================================
   // Selection for the current source
   wire logic src_ok = pg.src < rxpg_pkg::SRC_W'(NSRC);
   assign pg.rd_port = src_ok ? sel_rd[pg.src] : rxpg_pkg::LOCAL_READ_RST;
   assign pg.we_mask = src_ok ? sel_we[pg.src] : rxpg_pkg::LOCAL_WE_RST;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   source_isolation_a: assert property (
      (pg.sel_wr && pg.src != 3'h0) |=> ($stable(sel_rd[0]) && $stable(sel_we[0])))
      else $error("write by one source changed another source's paging");

   reset_defaults_a: assert property (
      disable iff (1'b0) $past(rst) |->
         (sel_rd[0] == 2'h0 && sel_we[0] == 4'h0 &&
          sel_rd[3] == 2'h1 && sel_we[3] == 4'h2 && sel_we[5] == 4'h8))
      else $error("paging defaults wrong after reset");

endmodule : rxpg_page_state

// file: dv/rxpg_blk_model.sv
// Model of the four receiver register blocks behind the paging block.
// Assumes one-cycle blk_we pulses; read data follows blk_addr at once.
`timescale 1ns/1ps
module rxpg_blk_model (
   // Clock
   input wire logic clk_sys,
   // Block access
   input wire logic [7:0] blk_addr,
   input wire logic [7:0] blk_wdata,
   input wire logic [3:0] blk_we,
   output logic [7:0] blk_rdata [4]
);
   logic [7:0] mem [4][256];

   // ==========================================
   // Storage
   initial
   begin
      for (int p = 0; p < 4; p++)
         for (int a = 0; a < 256; a++)
            mem[p][a] = 8'(a) ^ 8'(p * 85);
   end
   always @(posedge clk_sys)
      for (int p = 0; p < 4; p++)
         if (blk_we[p])
            mem[p][blk_addr] <= blk_wdata;
   always_comb
      for (int p = 0; p < 4; p++)
         blk_rdata[p] = mem[p][blk_addr];
endmodule : rxpg_blk_model

// file: dv/tb_rxpg_top.sv
// Testbench for the receiver register paging block.
// Assumes the block model answers combinationally from blk_addr.
`timescale 1ns/1ps
module tb_rxpg_top;
   logic clk_sys = 0;
   logic rst = 1;
   logic acc_valid = 0;
   logic acc_write = 0;
   logic [rxpg_pkg::SRC_W-1:0] acc_src = 0;
   logic [7:0] acc_addr = 0;
   logic [7:0] acc_wdata = 0;
   logic acc_rvalid;
   logic [7:0] acc_rdata, blk_addr, blk_wdata;
   logic [3:0] blk_we, blk_re;
   logic [7:0] blk_rdata [4];
   logic [7:0] mir [4][256];
   logic [1:0] rd [6];
   logic [3:0] we [6];
   logic [7:0] expq [$];
   logic [31:0] seed = 32'h5537;
   logic [31:0] r;
   logic [3:0] exp_re = 4'h0;
   logic [3:0] re_due = 4'h0;
   logic [7:0] tab [10] = '{8'h4C, 8'h4D, 8'h4E, 8'h7F, 8'hD0, 8'hDF, 8'h4B, 8'h80, 8'hCF, 8'hE0};
   int miscompares = 0;
   int tests_run = 0;

   always #2.5 clk_sys = ~clk_sys;

   rxpg_top dut_u (.clk_sys(clk_sys), .rst(rst), .acc_valid(acc_valid),
      .acc_write(acc_write), .acc_src(acc_src), .acc_addr(acc_addr),
      .acc_wdata(acc_wdata), .acc_rvalid(acc_rvalid), .acc_rdata(acc_rdata),
      .blk_addr(blk_addr), .blk_wdata(blk_wdata), .blk_we(blk_we),
      .blk_re(blk_re), .blk_rdata(blk_rdata));
   rxpg_blk_model blk_u (.clk_sys(clk_sys), .blk_addr(blk_addr),
      .blk_wdata(blk_wdata), .blk_we(blk_we), .blk_rdata(blk_rdata));

   // ==========================================
   // Helpers
   function automatic logic [31:0] xrand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xrand

   task automatic stop_test();
      if (expq.size() != 0)
         miscompares++;
      $display("checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   task automatic do_reset();
      @(posedge clk_sys);
      #1;
      acc_valid = 0;
      exp_re = 4'h0;
      rst = 1;
      repeat (10) @(posedge clk_sys);
      #1;
      rst = 0;
      for (int s = 0; s < 6; s++)
      begin
         rd[s] = s < 2 ? 2'h0 : 2'(s - 2);
         we[s] = s < 2 ? 4'h0 : 4'h1 << (s - 2);
      end
   endtask : do_reset

   task automatic idle(input int n);
      @(posedge clk_sys);
      #1;
      acc_valid = 0;
      exp_re = 4'h0;
      repeat (n) @(posedge clk_sys);
   endtask : idle

   // One access, with its expected read data noted
   task automatic acc(input logic [2:0] s, input logic w, input logic [7:0] a,
                      input logic [7:0] d);
      logic pg;
      @(posedge clk_sys);
      #1;
      acc_valid = 1;
      acc_write = w;
      acc_src = s;
      acc_addr = a;
      acc_wdata = d;
      pg = (a >= 8'h4D && a <= 8'h7F) || (a >= 8'hD0 && a <= 8'hDF);
      exp_re = (!w && pg && s < 6) ? 4'h1 << rd[s] : 4'h0;
      if (s > 5)
         return;
      if (!w)
         expq.push_back(a == 8'h4C ? {s < 2 ? 2'h0 : 2'(s - 2), rd[s], we[s]} :
            a == 8'h4D ? {rd[s], mir[rd[s]][a][5:0]} : pg ? mir[rd[s]][a] : 8'h00);
      else if (a == 8'h4C)
      begin
         rd[s] = d[5:4];
         we[s] = d[3:0];
      end
      else if (pg)
         for (int p = 0; p < 4; p++)
            if (we[s][p])
               mir[p][a] = d;
   endtask : acc

   task automatic sel_all();
      for (int s = 0; s < 8; s++)
         acc(3'(s), 1'b0, 8'h4C, 8'h00);
      idle(3);
   endtask : sel_all

   // ==========================================
   // Read data monitor
   always @(negedge clk_sys)
      if (acc_rvalid === 1'b1)
      begin
         tests_run++;
         if (expq.size() == 0 || acc_rdata !== expq[0])
         begin
            miscompares++;
            $display("wrong value at %0t: read data %h", $time, acc_rdata);
         end
         if (expq.size() != 0)
            void'(expq.pop_front());
      end

   // ==========================================
   // Read strobe check, one cycle after the request
   always @(posedge clk_sys)
      re_due <= exp_re;

   always @(negedge clk_sys)
      if (rst === 1'b0)
      begin
         tests_run++;
         if (blk_re !== re_due)
         begin
            miscompares++;
            $display("wrong value at %0t: read strobe %h", $time, blk_re);
         end
      end

   // ==========================================
   // Main sequence
   initial
   begin
      for (int p = 0; p < 4; p++)
         for (int a = 0; a < 256; a++)
            mir[p][a] = 8'(a) ^ 8'(p * 85);
      do_reset();
      sel_all();
      $display("test reset defaults done");
      for (int i = 0; i < 700; i++)
      begin
         r = xrand();
         acc(r[2:0], r[3], tab[r[7:4] % 10], r[15:8]);
      end
      idle(3);
      $display("test random traffic done");
      do_reset();
      sel_all();
      $display("test second reset done");
      stop_test();
   end

   initial
   begin
      #10000;
      miscompares++;
      stop_test();
   end
endmodule : tb_rxpg_top
